/* sepr_buf.sv */
// two-entry valid/ready buffer between byte reception and the array write port
`timescale 1ns/100ps
module sepr_buf #(
	parameter int W = 21
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic      [W-1:0] o_data
);

	typedef struct packed {
		logic [1:0]   cnt;
		logic [W-1:0] e0;
		logic [W-1:0] e1;
	} sepr_buf_st_t;

	sepr_buf_st_t r, s;
	logic         pop;
	logic         push;

	if (W < 1)
	begin : g_chk
		$error("sepr_buf: bad width");
	end

	assign o_ready = (r.cnt != 2'h2);
	assign o_valid = (r.cnt != 2'h0);
	assign o_data  = r.e0;

	always_comb
	begin
		s    = r;
		pop  = o_valid & i_ready;
		push = i_valid & o_ready;
		if (pop)
		begin
			s.e0 = r.e1;
		end
		if (push)
		begin
			if (r.cnt == 2'h0 || (r.cnt == 2'h1 && pop))
			begin
				s.e0 = i_data;
			end
			else
			begin
				s.e1 = i_data;
			end
		end
		s.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			r <= '0;
		end
		else
		begin
			r <= s;
		end
	end

endmodule

/* sepr_map.svh */
// constants for the serial eeprom command block: codes, field positions, reset values, timing
`ifndef SEPR_MAP_SVH
`define SEPR_MAP_SVH

`define SEPR_DEVTYPE_MEM    4'hA
`define SEPR_DEVTYPE_CFG    4'hB
`define SEPR_CFG_ENABLE     4'h5
`define SEPR_CFG_WSEL       2'h1
`define SEPR_WPR_PE_BIT     3
`define SEPR_WPR_BSH_BIT    2
`define SEPR_WPR_BSL_BIT    1
`define SEPR_WPR_SEL_BIT    7
`define SEPR_WPR_RST        3'h0
`define SEPR_DEV_ADDR_RST   3'h0
`define SEPR_PAGE_BITS      5
`define SEPR_ADDR_BITS      13
`define SEPR_T_WR_US        5000
`define SEPR_CLK_KHZ        25000
`define SEPR_WR_CYCLES      (`SEPR_T_WR_US * `SEPR_CLK_KHZ / 1000)

`endif

/* sepr_master.sv */
// two-wire bus master model driving link clock and data line
`timescale 1ns/100ps
module sepr_master (
	input  wire logic i_clk,
	input  wire logic i_oe,
	output logic      o_scl,
	output logic      o_sda
);
	logic sda_m;

	// pulled-up wire, low while either side pulls
	assign o_sda = sda_m & ~i_oe;

	initial
	begin
		o_scl = 1'b1;
		sda_m = 1'b1;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// data moves only with the link clock low; 8 clk per bit
	task automatic bit_io(input logic b, output logic s);
		sda_m <= b;
		tk(2);
		o_scl <= 1'b1;
		tk(4);
		s = o_sda;
		o_scl <= 1'b0;
		tk(2);
	endtask

	// long low wait lets the device drop its pull first, else a false stop
	task automatic start();
		sda_m <= 1'b1;
		tk(4);
		o_scl <= 1'b1;
		tk(4);
		sda_m <= 1'b0;
		tk(4);
		o_scl <= 1'b0;
		tk(2);
	endtask

	task automatic stop();
		sda_m <= 1'b0;
		tk(2);
		o_scl <= 1'b1;
		tk(4);
		sda_m <= 1'b1;
		tk(4);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(~mack, s);
	endtask
endmodule

/* sepr_mem.sv */
// byte array of the eeprom with one write port and a registered read port
`timescale 1ns/100ps
module sepr_mem #(
	parameter int AW = 13,
	parameter int DW = 8
) (
	input  wire logic          i_clk,
	input  wire logic          i_re,
	input  wire logic [AW-1:0] i_raddr,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [DW-1:0] i_wdata,
	output logic      [DW-1:0] o_rdata
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	if (AW < 1 || DW < 1)
	begin : g_chk
		$error("sepr_mem: bad geometry");
	end

	// no reset: cell contents are what the array holds, not control state
	always_ff @(posedge i_clk)
	begin
		if (i_we)
		begin
			mem[i_waddr] <= i_wdata;
		end
		if (i_re)
		begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule

/* sepr_pkg.sv */
// types shared by the serial eeprom command block
package sepr_pkg;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_ACKH, ST_TX, ST_MACK, ST_TXW} sepr_state_t;

	typedef enum logic [1:0] {K_DEV, K_AHI, K_ALO, K_DATA} sepr_kind_t;

	typedef struct packed {
		logic [12:0] addr;
		logic [7:0]  data;
	} sepr_wr_t;

	typedef struct packed {
		logic       pe;
		logic [1:0] bs;
	} sepr_wpr_t;

	typedef struct packed {
		logic        scl_m;
		logic        scl_s;
		logic        scl_d;
		logic        sda_m;
		logic        sda_s;
		logic        sda_d;
		sepr_state_t state;
		sepr_kind_t  kind;
		logic [3:0]  bitc;
		logic [7:0]  sh;
		logic        tx;
		logic        oe;
		logic        sda_o;
		logic        device_address_change;
		logic        sel_wpr;
		logic        wda_arm;
		logic        wda_pend;
		logic        reject;
		logic [1:0]  dcnt;
		logic [7:0]  ahi;
		logic [7:0]  pend;
		logic [12:0] ctr;
		sepr_wpr_t   write_protect_config;
		logic [2:0]  dev_addr;
		logic [23:0] busy_cnt;
		logic        busy;
		logic        mem_rd;
		logic        push;
		sepr_wr_t    push_d;
	} sepr_regs_t;

endpackage

/* sepr_top.sv */
// command logic of a two-wire serial eeprom slave with write-protect register
// Contract
// (R1) write: device address, two word-address bytes, data byte, each acknowledged low
// (R2) stop after a write starts a timed cycle; bus ignored until done
// (R3) page write takes up to 32 bytes, each acknowledged
// (R4) each data byte bumps only the low five address bits
// (R5) no acknowledge to a device address during the write cycle
// (R6) enable byte with upper nibble 0101 precedes address change, not acknowledged
// (R7) address change uses type 1011, word-address bits ten and nine must be 01
// (R8) new configurable address is the low three data bits
// (R9) word address with top bit set selects the protect register
// (R10) protect bits one to three are kept as nonvolatile state; here every reset clears them to 000
// (R11) protect-enable one enforces block protection, zero allows all writes
// (R12) block select 00,01,10,11 protect from 1800,1000,0800,0000 up to 1FFF
// (R13) write to a protected address: data byte not acknowledged, write rejected
// (R14) protect register write with more than one byte is abandoned
// (R15) protect register bit3 enable, bit2/bit1 block select, others read zero
// (R16) address counter holds last address plus one; current read uses it
// (R17) master ends a read by not acknowledging, then stop
// (R18) master acknowledge after a byte fetches the next byte
// (R19) read counter wraps past the top address to zero
// (R20) random read: dummy write loads counter, new start discards pending write
// (R21) protect register read repeats the same value for further bytes
// (R22) protect register cannot be read during a write cycle
// (R23) respond only to type 1010 with matching address; bit zero selects read
// (R24) acknowledge each received byte by pulling data low on the ninth clock
// (R25) configurable address starts from its stored value, factory zero; here every reset loads 000 instead
// (R26) address change without directly preceding enable is ignored
`timescale 1ns/100ps
`include "sepr_map.svh"
module sepr_top #(
	parameter int WR_CYCLES = `SEPR_WR_CYCLES
) (
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	output logic            o_write_busy,
	output logic [2:0]      o_protect_cfg,
	output logic [2:0]      o_dev_addr
);

	localparam int AW = `SEPR_ADDR_BITS;
	localparam int WRW = $bits(sepr_pkg::sepr_wr_t);

	sepr_pkg::sepr_regs_t r, s;
	sepr_pkg::sepr_wr_t   buf_q;
	logic                 rst_m;
	logic                 rst_s;
	logic                 buf_ready;
	logic                 buf_valid;
	logic [7:0]           mem_q;
	logic                 rise;
	logic                 fall;
	logic                 start;
	logic                 stop;
	logic [7:0]           b;
	logic [7:0]           wpr_byte;
	logic                 prot;

	if (WR_CYCLES < 1 || WR_CYCLES >= (1 << 24))
	begin : g_chk
		$error("sepr_top: write cycle count out of range");
	end

	// reset asserts at once and leaves through two flops
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end
		else
		begin
			rst_m <= 1'b1;
			rst_s <= rst_m;
		end
	end

	sepr_mem #(
		.AW (AW),
		.DW (8)
	) u_mem (
		.i_clk   (i_clk),
		.i_re    (r.mem_rd),
		.i_raddr (r.ctr),
		.i_we    (buf_valid & ~r.mem_rd),
		.i_waddr (buf_q.addr),
		.i_wdata (buf_q.data),
		.o_rdata (mem_q)
	);

	// array writes wait out any cycle with a read, although the array has a separate read port
	sepr_buf #(
		.W (WRW)
	) u_buf (
		.i_clk   (i_clk),
		.i_rst_n (rst_s),
		.i_valid (r.push),
		.o_ready (buf_ready),
		.i_data  (r.push_d),
		.o_valid (buf_valid),
		.i_ready (~r.mem_rd),
		.o_data  (buf_q)
	);

	assign rise  = r.scl_s & ~r.scl_d;
	assign fall  = ~r.scl_s & r.scl_d;
	assign start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
	assign stop  = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
	assign b     = {r.sh[6:0], r.sda_s};

	// unused bits of the register read back as zero
	assign wpr_byte = {4'h0, r.write_protect_config.pe, r.write_protect_config.bs, 1'b0}; // R15

	// top two address bits against the inverted block select gives the protected range
	assign prot = r.write_protect_config.pe & (r.ctr[12:11] >= ~r.write_protect_config.bs); // R11 R12

	always_comb
	begin
		s        = r;
		s.mem_rd = 1'b0;
		s.push   = 1'b0;
		s.sda_o  = 1'b0;
		s.scl_m  = i_scl;
		s.scl_s  = r.scl_m;
		s.scl_d  = r.scl_s;
		s.sda_m  = i_sda;
		s.sda_s  = r.sda_m;
		s.sda_d  = r.sda_s;
		if (r.busy_cnt != 24'h0)
		begin
			// during the write cycle the line is left alone, so every address goes unanswered
			s.busy_cnt = r.busy_cnt - 24'h1; // R2 R5 R22
			s.state    = sepr_pkg::ST_IDLE;
			s.oe       = 1'b0;
		end
		else if (start)
		begin
			// any pending dummy write is dropped here; the counter was already loaded
			s.state    = sepr_pkg::ST_RX; // R20
			s.kind     = sepr_pkg::K_DEV;
			s.bitc     = 4'h0;
			s.oe       = 1'b0;
			s.wda_arm  = r.wda_pend; // R26
			s.wda_pend = 1'b0;
			s.device_address_change      = 1'b0;
			s.dcnt     = 2'h0;
			s.reject   = 1'b0;
			s.tx       = 1'b0;
		end
		else if (stop)
		begin
			s.state = sepr_pkg::ST_IDLE; // R17
			s.oe    = 1'b0;
			if (!r.tx && r.kind == sepr_pkg::K_DATA && r.dcnt != 2'h0 && !r.reject)
			begin
				if (r.device_address_change)
				begin
					s.wda_arm = 1'b0;
					if (r.wda_arm && r.ahi[2:1] == `SEPR_CFG_WSEL) // R7
					begin
						s.dev_addr = r.pend[2:0]; // R8
						s.busy_cnt = 24'(WR_CYCLES); // R2
					end
				end
				else if (r.sel_wpr)
				begin
					if (r.dcnt == 2'h1) // R14
					begin
						s.write_protect_config.pe   = r.pend[`SEPR_WPR_PE_BIT]; // R10 R15
						s.write_protect_config.bs   = {r.pend[`SEPR_WPR_BSH_BIT], r.pend[`SEPR_WPR_BSL_BIT]};
						s.busy_cnt = 24'(WR_CYCLES);
					end
				end
				else
				begin
					s.busy_cnt = 24'(WR_CYCLES); // R2
				end
			end
		end
		else
		begin
			case (r.state)
				sepr_pkg::ST_RX:
				begin
					if (rise)
					begin
						s.sh   = b;
						s.bitc = r.bitc + 4'h1;
						if (r.bitc == 4'h7)
						begin
							s.state = sepr_pkg::ST_ACK;
							case (r.kind)
								sepr_pkg::K_DEV:
								begin
									if (b[7:4] == `SEPR_CFG_ENABLE)
									begin
										s.wda_pend = 1'b1; // R6
										s.state    = sepr_pkg::ST_IDLE;
									end
									else if (b[3:1] == r.dev_addr && b[7:4] == `SEPR_DEVTYPE_MEM)
									begin
										s.tx     = b[0]; // R23
										s.kind   = sepr_pkg::K_AHI;
										s.mem_rd = b[0] & ~r.sel_wpr; // R16
									end
									else if (b[3:1] == r.dev_addr && b[7:4] == `SEPR_DEVTYPE_CFG
										&& !b[0] && r.wda_arm)
									begin
										s.device_address_change  = 1'b1; // R7 R26
										s.kind = sepr_pkg::K_AHI;
									end
									else
									begin
										s.state = sepr_pkg::ST_IDLE; // R23 R26
									end
								end
								sepr_pkg::K_AHI:
								begin
									s.ahi  = b; // R1
									s.kind = sepr_pkg::K_ALO;
									if (!r.device_address_change)
									begin
										s.sel_wpr = b[`SEPR_WPR_SEL_BIT]; // R9
									end
								end
								sepr_pkg::K_ALO:
								begin
									s.kind = sepr_pkg::K_DATA; // R1
									if (!r.device_address_change && !r.sel_wpr)
									begin
										s.ctr = {r.ahi[4:0], b}; // R20
									end
								end
								default:
								begin
									s.pend = b;
									if (r.dcnt != 2'h2)
									begin
										s.dcnt = r.dcnt + 2'h1;
									end
									if (!r.device_address_change && !r.sel_wpr)
									begin
										if (prot || !buf_ready)
										begin
											// no acknowledge; stop will then start no cycle
											s.reject = 1'b1; // R13
											s.state  = sepr_pkg::ST_IDLE;
										end
										else
										begin
											s.push        = 1'b1; // R3
											s.push_d.addr = r.ctr;
											s.push_d.data = b;
											s.ctr[`SEPR_PAGE_BITS-1:0] =
												r.ctr[`SEPR_PAGE_BITS-1:0] + 5'h1; // R4
										end
									end
								end
							endcase
						end
					end
				end
				sepr_pkg::ST_ACK:
				begin
					if (fall)
					begin
						s.oe    = 1'b1; // R24
						s.state = sepr_pkg::ST_ACKH;
					end
				end
				sepr_pkg::ST_ACKH:
				begin
					if (fall)
					begin
						s.oe   = 1'b0;
						s.bitc = 4'h0;
						if (r.tx)
						begin
							s.sh    = r.sel_wpr ? wpr_byte : mem_q; // R16 R21
							s.oe    = r.sel_wpr ? ~wpr_byte[7] : ~mem_q[7];
							s.bitc  = 4'h1;
							s.state = sepr_pkg::ST_TX;
							if (!r.sel_wpr)
							begin
								s.ctr = r.ctr + 13'h1; // R16 R19
							end
						end
						else
						begin
							s.state = sepr_pkg::ST_RX;
						end
					end
				end
				sepr_pkg::ST_TX:
				begin
					if (fall)
					begin
						if (r.bitc == 4'h8)
						begin
							s.oe    = 1'b0;
							s.state = sepr_pkg::ST_MACK;
						end
						else
						begin
							s.oe   = ~r.sh[6];
							s.sh   = {r.sh[6:0], 1'b0};
							s.bitc = r.bitc + 4'h1;
						end
					end
				end
				sepr_pkg::ST_MACK:
				begin
					if (rise)
					begin
						if (!r.sda_s)
						begin
							s.mem_rd = ~r.sel_wpr; // R18
							s.state  = sepr_pkg::ST_TXW;
						end
						else
						begin
							s.state = sepr_pkg::ST_IDLE; // R17
						end
					end
				end
				sepr_pkg::ST_TXW:
				begin
					if (fall)
					begin
						// the fetched byte settled well before this falling edge
						s.sh    = r.sel_wpr ? wpr_byte : mem_q; // R18 R21
						s.oe    = r.sel_wpr ? ~wpr_byte[7] : ~mem_q[7];
						s.bitc  = 4'h1;
						s.state = sepr_pkg::ST_TX;
						if (!r.sel_wpr)
						begin
							s.ctr = r.ctr + 13'h1; // R19
						end
					end
				end
				default:
				begin
					s.oe = 1'b0;
				end
			endcase
		end
		s.busy = (s.busy_cnt != 24'h0);
	end

	always_ff @(posedge i_clk or negedge rst_s)
	begin
		if (!rst_s)
		begin
			r          <= '0;
			r.scl_m    <= 1'b1;
			r.scl_s    <= 1'b1;
			r.scl_d    <= 1'b1;
			r.sda_m    <= 1'b1;
			r.sda_s    <= 1'b1;
			r.sda_d    <= 1'b1;
			r.write_protect_config      <= `SEPR_WPR_RST; // R10
			r.dev_addr <= `SEPR_DEV_ADDR_RST; // R25
		end
		else
		begin
			r <= s;
		end
	end

	assign o_sda_out     = r.sda_o;
	assign o_sda_oe      = r.oe;
	assign o_write_busy  = r.busy;
	assign o_protect_cfg = r.write_protect_config;
	assign o_dev_addr    = r.dev_addr;

endmodule

/* sepr_top_asserts.sv */
// port checks for the serial eeprom command block
`timescale 1ns/100ps
module sepr_top_asserts #(
	parameter int WR_CYCLES = 125000
) (
	input wire logic       i_clk,
	input wire logic       i_resetn,
	input wire logic       i_scl,
	input wire logic       i_sda,
	input wire logic       o_sda_out,
	input wire logic       o_sda_oe,
	input wire logic       o_write_busy,
	input wire logic [2:0] o_protect_cfg,
	input wire logic [2:0] o_dev_addr
);
	int busy_n;

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			busy_n <= 0;
		else if (o_write_busy)
			busy_n <= busy_n + 1;
		else
			busy_n <= 0;
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	out_zero_a: assert property (o_sda_out == 1'b0)
		else $error("data output not zero");
	busy_quiet_a: assert property (o_write_busy |-> !o_sda_oe)
		else $error("line pulled during write cycle");
	busy_stop_a: assert property ($rose(o_write_busy) |-> i_scl && i_sda)
		else $error("write cycle began without stop");
	busy_len_a: assert property ($fell(o_write_busy) |->
		busy_n >= WR_CYCLES - 1 && busy_n <= WR_CYCLES + 1)
		else $error("write cycle length wrong");
	busy_cap_a: assert property (busy_n <= WR_CYCLES + 1)
		else $error("write cycle too long");
	cfg_idle_a: assert property (!$stable(o_protect_cfg) |-> i_scl && i_sda)
		else $error("protect bits changed mid frame");
	addr_idle_a: assert property (!$stable(o_dev_addr) |-> i_scl && i_sda)
		else $error("device address changed mid frame");
	oe_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*6])
		else $error("pull shorter than a bit");
	rst_vals_a: assert property ($rose(i_resetn) |->
		o_protect_cfg == 3'h0 && o_dev_addr == 3'h0 && !o_write_busy && !o_sda_oe)
		else $error("reset values wrong");

	cover property ($rose(o_write_busy));
	cover property ($rose(o_protect_cfg[2]));
	cover property (!$stable(o_dev_addr));
endmodule

bind sepr_top sepr_top_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (
	.i_clk        (i_clk),
	.i_resetn     (i_resetn),
	.i_scl        (i_scl),
	.i_sda        (i_sda),
	.o_sda_out    (o_sda_out),
	.o_sda_oe     (o_sda_oe),
	.o_write_busy (o_write_busy),
	.o_protect_cfg(o_protect_cfg),
	.o_dev_addr   (o_dev_addr)
);

/* sepr_top_bench.sv */
// self-checking bench for the serial eeprom command block
`timescale 1ns/100ps
module sepr_top_bench;
	logic            clk;
	logic            rst_n;
	wire logic       scl;
	wire logic       sda;
	wire logic       oe;
	wire logic       busy;
	wire logic [2:0] cfg;
	wire logic [2:0] dev;
	int              failures;
	int              checked;
	int              cyc;
	logic [7:0]      dw;
	logic [15:0]     a;

	sepr_master m (.i_clk(clk), .i_oe(oe), .o_scl(scl), .o_sda(sda));
	sepr_top #(.WR_CYCLES(400)) uut (.i_clk(clk), .i_resetn(rst_n), .i_scl(scl),
		.i_sda(sda), .o_sda_out(), .o_sda_oe(oe), .o_write_busy(busy),
		.o_protect_cfg(cfg), .o_dev_addr(dev));

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic cmd(input logic [7:0] b, input int e);
		logic ak;
		m.wbyte(b, ak);
		chk({7'h0, ak}, 8'(e));
	endtask

	task automatic idle();
		int n;
		n = 0;
		m.tk(4);
		while (busy !== 1'b0 && n < 600)
		begin
			m.tk(1);
			n++;
		end
		chk({7'h0, busy}, 8'h00);
	endtask

	task automatic wr(input logic [15:0] ad, input logic [7:0] d, input int e);
		m.start();
		cmd(dw, 1);
		cmd(ad[15:8], 1);
		cmd(ad[7:0], 1);
		cmd(d, e);
		m.stop();
		idle();
	endtask

	task automatic seta(input logic [15:0] ad);
		m.start();
		cmd(dw, 1);
		cmd(ad[15:8], 1);
		cmd(ad[7:0], 1);
		m.start();
		cmd(dw | 8'h01, 1);
	endtask

	task automatic rd(input logic [7:0] e, input int last);
		logic [7:0] d;
		m.rbyte(!last, d);
		chk(d, e);
		if (last)
			m.stop();
	endtask

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			failures++;
			summarize();
		end
	end

	initial
	begin
		rst_n = 1'b0;
		dw = 8'hA0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		m.tk(6);
		chk({5'h0, cfg}, 8'h00);
		chk({5'h0, dev}, 8'h00);
		wr(16'h0123, 8'h5A, 1);
		wr(16'h1FFF, 8'h77, 1);
		wr(16'h0000, 8'h88, 1);
		seta(16'h0123);
		rd(8'h5A, 1);
		seta(16'h1FFF);
		rd(8'h77, 1);
		m.start();
		cmd(dw | 8'h01, 1);
		rd(8'h88, 1);
		m.start();
		cmd(dw, 1);
		cmd(8'h00, 1);
		cmd(8'h3E, 1);
		for (int i = 1; i < 4; i++)
			cmd(8'(i * 17), 1);
		m.stop();
		m.start();
		cmd(dw, 0);
		m.start();
		cmd(dw | 8'h01, 0);
		m.stop();
		idle();
		seta(16'h003E);
		rd(8'h11, 0);
		rd(8'h22, 1);
		seta(16'h0020);
		rd(8'h33, 1);
		wr(16'h8000, 8'hFF, 1);
		chk({5'h0, cfg}, 8'h07);
		seta(16'hFFFF);
		rd(8'h0E, 0);
		rd(8'h0E, 1);
		for (int b = 0; b < 4; b++)
		begin
			wr(16'h8000, {4'h0, 1'b1, b[1:0], 1'b0}, 1);
			a = {3'b000, ~b[1:0], 11'h000};
			wr(a, 8'h99, 0);
			if (b < 3)
				wr(a - 16'h0001, 8'h66, 1);
		end
		seta(16'h0000);
		rd(8'h88, 1);
		m.start();
		cmd(dw, 1);
		cmd(8'h80, 1);
		cmd(8'h00, 1);
		// two data bytes to the protect register: the write must be abandoned
		cmd(8'h00, 1);
		cmd(8'h00, 1);
		m.stop();
		idle();
		chk({5'h0, cfg}, 8'h07);
		wr(16'h8000, 8'h00, 1);
		chk({5'h0, cfg}, 8'h00);
		wr(16'h1FFF, 8'h66, 1);
		m.start();
		cmd(8'hB0, 0);
		m.stop();
		chk({5'h0, dev}, 8'h00);
		m.start();
		cmd(8'h50, 0);
		m.start();
		cmd(8'hB0, 1);
		cmd(8'h02, 1);
		cmd(8'h00, 1);
		cmd(8'hF5, 1);
		m.stop();
		idle();
		chk({5'h0, dev}, 8'h05);
		m.start();
		cmd(8'hA0, 0);
		m.stop();
		dw = 8'hAA;
		seta(16'h0123);
		rd(8'h5A, 1);
		summarize();
	end
endmodule
